// >>> common/pgd_pkg.sv
// Contract
// - Power good is raised only after the programmed delay has run out since the output went above the power-good-on level.
// - The power-good delay spans 0 ms to 125 ms in millisecond units.
// - A written power-good delay outside that span is refused and the old setting stays.
// - Bits 11:0 of the loop tuning register hold a 12-bit settle threshold, any value 0 to FFF hex.
// - While settled the loop gain is divided by 1, 2, 4 or 8 as bits 13:12 select 00, 01, 10, 11.
// - The loop tuning register resets to 2064 hex, divide by four with threshold 64 hex.
// - The inductor value in microhenries, above zero up to 100, is decoded and driven out on inductor_q16.
// - A set mask bit keeps its fault type from starting a capture and its store; reset masks nothing.
// - Mask bits 15 to 11 cover phase, group, processor, under-temperature and over-temperature faults.
// - Mask bit 10 covers peak overcurrent and bit 9 peak undercurrent faults.
// - Mask bit 8 covers faults arriving on the enable pin used as a fault bus.
// - Mask bit 7 covers input overvoltage, bit 6 output overvoltage, bit 5 output undervoltage.
// - Mask bit 3 covers loss of sync, bit 2 input undervoltage, and bit 4 does nothing.
// - Mask bit 1 covers average overcurrent and bit 0 average undercurrent faults.
package pgd_pkg;
	localparam int CLK_NS     = 25;
	localparam int MS_NS      = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	localparam int CPM_W      = 16;
	localparam int CNT_W      = 24;

	localparam logic [7:0] CMD_PG_DELAY = 8'hD4;
	localparam logic [7:0] CMD_LOOP     = 8'hD5;
	localparam logic [7:0] CMD_IND      = 8'hD6;
	localparam logic [7:0] CMD_MASK     = 8'hD7;

	localparam logic [15:0] RST_PG_DELAY = 16'hBA00;
	localparam logic [15:0] RST_LOOP     = 16'h2064;
	localparam logic [15:0] RST_IND      = 16'hAA66;
	localparam logic [15:0] RST_MASK     = 16'h0000;

	// Linear-11 layout and fixed-point form of decoded values
	localparam int MANT_W   = 11;
	localparam int EXP_LSB  = 11;
	localparam int LIN_W    = 44;
	localparam int LIN_FRAC = 16;
	localparam int DLY_MAX_MS = 125;
	localparam int IND_MAX_UH = 100;
	localparam logic [LIN_W-1:0] DLY_MAX_Q = LIN_W'(DLY_MAX_MS) << LIN_FRAC;
	localparam logic [LIN_W-1:0] IND_MAX_Q = LIN_W'(IND_MAX_UH) << LIN_FRAC;

	localparam int THR_LSB = 0;
	localparam int THR_W   = 12;
	localparam int DIV_LSB = 12;
	localparam int DIV_W   = 2;
	localparam logic [15:0] LOOP_USED = 16'h3FFF;

	localparam int MB_PHASE   = 15;
	localparam int MB_GROUP   = 14;
	localparam int MB_CPU     = 13;
	localparam int MB_UT      = 12;
	localparam int MB_OT      = 11;
	localparam int MB_PEAK_OC = 10;
	localparam int MB_PEAK_UC = 9;
	localparam int MB_EN_BUS  = 8;
	localparam int MB_VIN_OV  = 7;
	localparam int MB_VOUT_OV = 6;
	localparam int MB_VOUT_UV = 5;
	localparam int MB_UNUSED  = 4;
	localparam int MB_SYNC    = 3;
	localparam int MB_VIN_UV  = 2;
	localparam int MB_AVG_OC  = 1;
	localparam int MB_AVG_UC  = 0;
	localparam logic [15:0] MASK_VALID = 16'hFFEF;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] data;
	} pgd_cmd_s;

	typedef struct packed {
		logic        valid;
		logic        ok;
		logic [15:0] data;
	} pgd_rsp_s;

	typedef enum logic [2:0] {
		PG_IDLE = 3'b001,
		PG_WAIT = 3'b010,
		PG_GOOD = 3'b100
	} pgd_pg_e;
endpackage

// >>> hdl/pgd_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pgd_delay_timer import pgd_pkg::*; #(
	parameter int W = CNT_W
) (
	// Clock, reset, enable
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// Control
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output var  logic         expired
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		expired  = run && (cnt >= limit);
		next_cnt = cnt;
		if (!run)
			next_cnt = '0;
		else if (!expired)
			next_cnt = cnt + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			cnt <= '0;
		else if (ce)
			cnt <= next_cnt;
	end
endmodule
`default_nettype wire

// >>> hdl/pgd_lin11.sv
`timescale 1ns/1ps
`default_nettype none
module pgd_lin11 import pgd_pkg::*; (
	// Linear-11 word in
	input  wire logic              [15:0]      word,
	// Value scaled by two to the LIN_FRAC
	output var  logic signed [LIN_W-1:0] value
);
	logic [4:0] shamt;

	// Exponent spans -16..15, so adding 16 only flips its sign bit
	always_comb begin
		shamt = {~word[15], word[14:EXP_LSB]};
		value = $signed({{(LIN_W-MANT_W){word[MANT_W-1]}},
			word[MANT_W-1:0]}) <<< shamt;
	end
endmodule
`default_nettype wire

// >>> hdl/pgd_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module pgd_regs_top import pgd_pkg::*; #(
	parameter int CYC_PER_MS_P = CYC_PER_MS,
	parameter int GAIN_W       = 16
) (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	// Command port
	input  wire pgd_cmd_s          cmd,
	output var  pgd_rsp_s          rsp,
	// Power good
	input  wire logic              vout_above_pg_on,
	output var  logic              power_good_output,
	// Adaptive loop
	input  wire logic [THR_W-1:0]  vout_error,
	input  wire logic [GAIN_W-1:0] base_gain,
	output var  logic [GAIN_W-1:0] adaptive_loop_gain,
	output var  logic              loop_settled,
	// Inductor
	output var  logic [LIN_W-1:0]  inductor_q16,
	// Fault capture
	input  wire logic [15:0]       fault_events,
	output var  logic              fault_capture_record,
	output var  logic [15:0]       fault_capture_cause
);
	logic [15:0]              dly_reg;
	logic [15:0]              loop_reg;
	logic [15:0]              ind_reg;
	logic [15:0]              mask_reg;
	logic [15:0]              next_dly;
	logic [15:0]              next_loop;
	logic [15:0]              next_ind;
	logic [15:0]              next_mask;
	pgd_rsp_s                 next_rsp;
	logic signed [LIN_W-1:0]  wr_val;
	logic signed [LIN_W-1:0]  dly_val;
	logic signed [LIN_W-1:0]  ind_val;
	logic                     dly_ok;
	logic                     ind_ok;
	logic [THR_W-1:0]         thr;
	logic [DIV_W-1:0]         div_sel;

	pgd_lin11 u_wr_dec (
		.word  (cmd.data),
		.value (wr_val)
	);

	pgd_lin11 u_dly_dec (
		.word  (dly_reg),
		.value (dly_val)
	);

	pgd_lin11 u_ind_dec (
		.word  (ind_reg),
		.value (ind_val)
	);

	// Command handling: one answer per command, on the following edge
	always_comb begin
		dly_ok = !wr_val[LIN_W-1] && (wr_val <= DLY_MAX_Q);
		ind_ok = !wr_val[LIN_W-1] && (wr_val != '0)
			&& (wr_val <= IND_MAX_Q);
		next_dly  = dly_reg;
		next_loop = loop_reg;
		next_ind  = ind_reg;
		next_mask = mask_reg;
		next_rsp  = '0;
		if (cmd.valid) begin
			next_rsp.valid = 1'b1;
			next_rsp.ok    = 1'b1;
			case (cmd.code)
				CMD_PG_DELAY: begin
					next_rsp.data = dly_reg;
					if (cmd.write) begin
						next_rsp.ok = dly_ok;
						if (dly_ok)
							next_dly = cmd.data;
					end
				end
				CMD_LOOP: begin
					next_rsp.data = loop_reg;
					if (cmd.write)
						next_loop = cmd.data & LOOP_USED;
				end
				CMD_IND: begin
					next_rsp.data = ind_reg;
					if (cmd.write) begin
						next_rsp.ok = ind_ok;
						if (ind_ok)
							next_ind = cmd.data;
					end
				end
				CMD_MASK: begin
					next_rsp.data = mask_reg;
					if (cmd.write)
						next_mask = cmd.data;
				end
				default: begin
					next_rsp.ok = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dly_reg  <= RST_PG_DELAY;
			loop_reg <= RST_LOOP;
			ind_reg  <= RST_IND;
			mask_reg <= RST_MASK;
			rsp      <= '0;
		end else if (ce) begin
			dly_reg  <= next_dly;
			loop_reg <= next_loop;
			ind_reg  <= next_ind;
			mask_reg <= next_mask;
			rsp      <= next_rsp;
		end
	end

	// Power good sequencing
	logic                       above_meta;
	logic                       above_sync;
	pgd_pg_e                    state;
	pgd_pg_e                    next_state;
	logic [CNT_W-1:0]           pg_limit;
	logic [CNT_W-1:0]           next_limit;
	logic [LIN_W+CPM_W-1:0]     dly_prod;
	logic                       tmr_expired;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			above_meta <= 1'b0;
			above_sync <= 1'b0;
		end else if (ce) begin
			above_meta <= vout_above_pg_on;
			above_sync <= above_meta;
		end
	end

	pgd_delay_timer #(
		.W (CNT_W)
	) u_pg_timer (
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.run     (state == PG_WAIT),
		.limit   (pg_limit),
		.expired (tmr_expired)
	);

	// Range check keeps the product below the counter width
	always_comb begin
		dly_prod   = $unsigned(dly_val) * CPM_W'(CYC_PER_MS_P);
		next_limit = dly_prod[LIN_FRAC +: CNT_W];
		next_state = state;
		case (state)
			PG_IDLE: begin
				if (above_sync)
					next_state = PG_WAIT;
			end
			PG_WAIT: begin
				if (!above_sync)
					next_state = PG_IDLE;
				else if (tmr_expired)
					next_state = PG_GOOD;
			end
			PG_GOOD: begin
				if (!above_sync)
					next_state = PG_IDLE;
			end
			default: begin
				next_state = PG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state             <= PG_IDLE;
			pg_limit          <= '0;
			power_good_output <= 1'b0;
		end else if (ce) begin
			state             <= next_state;
			pg_limit          <= next_limit;
			power_good_output <= (next_state == PG_GOOD);
		end
	end

	// Adaptive loop gain and inductor value
	logic [GAIN_W-1:0] next_gain;
	logic              next_settled;

	always_comb begin
		thr          = loop_reg[THR_LSB +: THR_W];
		div_sel      = loop_reg[DIV_LSB +: DIV_W];
		next_settled = (vout_error <= thr);
		next_gain    = base_gain;
		if (next_settled)
			next_gain = base_gain >> div_sel;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			adaptive_loop_gain <= '0;
			loop_settled       <= 1'b0;
			inductor_q16       <= '0;
		end else if (ce) begin
			adaptive_loop_gain <= next_gain;
			loop_settled       <= next_settled;
			inductor_q16       <= $unsigned(ind_val);
		end
	end

	// Fault capture: bit 4 never fires, whatever the mask holds
	logic [15:0] hit;
	logic        next_record;
	logic [15:0] next_cause;

	always_comb begin
		hit         = fault_events & ~mask_reg & MASK_VALID;
		next_record = |hit;
		next_cause  = fault_capture_cause;
		if (next_record)
			next_cause = hit;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fault_capture_record <= 1'b0;
			fault_capture_cause  <= '0;
		end else if (ce) begin
			fault_capture_record <= next_record;
			fault_capture_cause  <= next_cause;
		end
	end

	property p_pg_rise;
		@(posedge clk) disable iff (!resetn)
		$rose(power_good_output) |-> $past(state) == PG_WAIT
			&& $past(tmr_expired);
	endproperty
	a_pg_rise: assert property (p_pg_rise)
		else $error("power good rose without delay expiry");

	property p_pg_drop;
		@(posedge clk) disable iff (!resetn)
		ce && !above_sync |=> !power_good_output;
	endproperty
	a_pg_drop: assert property (p_pg_drop)
		else $error("power good held while output low");

	property p_dly_range;
		@(posedge clk) disable iff (!resetn)
		!dly_val[LIN_W-1] && dly_val <= DLY_MAX_Q;
	endproperty
	a_dly_range: assert property (p_dly_range)
		else $error("stored delay out of range");

	property p_dly_keep;
		@(posedge clk) disable iff (!resetn)
		ce && cmd.valid && cmd.write && cmd.code == CMD_PG_DELAY
			&& !dly_ok |=> $stable(dly_reg) && !rsp.ok;
	endproperty
	a_dly_keep: assert property (p_dly_keep)
		else $error("bad delay write was accepted");

	property p_thr_write;
		@(posedge clk) disable iff (!resetn)
		ce && cmd.valid && cmd.write && cmd.code == CMD_LOOP
			|=> thr == $past(cmd.data[THR_W-1:0]);
	endproperty
	a_thr_write: assert property (p_thr_write)
		else $error("threshold not stored");

	property p_gain_div;
		@(posedge clk) disable iff (!resetn)
		ce && vout_error <= thr |=> loop_settled
			&& adaptive_loop_gain == ($past(base_gain) >> $past(div_sel));
	endproperty
	a_gain_div: assert property (p_gain_div)
		else $error("settled gain not divided");

	property p_rst_vals;
		@(posedge clk) disable iff (!resetn)
		$past(!resetn) |-> loop_reg == RST_LOOP && mask_reg == RST_MASK;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("wrong reset value");

	property p_ind_range;
		@(posedge clk) disable iff (!resetn)
		!ind_val[LIN_W-1] && ind_val != '0 && ind_val <= IND_MAX_Q;
	endproperty
	a_ind_range: assert property (p_ind_range)
		else $error("stored inductor out of range");

	property p_mask_block;
		@(posedge clk) disable iff (!resetn)
		ce && (fault_events & ~mask_reg & MASK_VALID) == '0
			|=> !fault_capture_record;
	endproperty
	a_mask_block: assert property (p_mask_block)
		else $error("masked fault started a capture");

	property p_ot_capture;
		@(posedge clk) disable iff (!resetn)
		ce && fault_events[MB_OT] && !mask_reg[MB_OT]
			|=> fault_capture_record && fault_capture_cause[MB_OT];
	endproperty
	a_ot_capture: assert property (p_ot_capture)
		else $error("unmasked fault not captured");

	property p_bit4;
		@(posedge clk) disable iff (!resetn)
		!fault_capture_cause[MB_UNUSED];
	endproperty
	a_bit4: assert property (p_bit4)
		else $error("unused fault bit captured");
endmodule
`default_nettype wire

// >>> verif/pgd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgd_host_model import pgd_pkg::*; (
	// Clock
	input  wire logic     clk,
	// Command port
	output var  pgd_cmd_s cmd,
	input  wire pgd_rsp_s rsp
);
	initial begin
		cmd = '0;
	end

	// Held from one falling edge to the next, so the taking edge is inside
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] d, output logic [1:0] st, output logic [15:0] q);
		@(negedge clk);
		cmd = {1'b1, wr, code, d};
		@(negedge clk);
		st = {rsp.valid, rsp.ok};
		q = rsp.data;
		// Idle fields show the inverse, never a stale copy of the request
		cmd = {1'b0, ~wr, ~code, ~d};
	endtask
endmodule
`default_nettype wire

// >>> verif/pgd_regs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pgd_regs_top_tb_top import pgd_pkg::*;;
	logic             clk;
	logic             resetn;
	logic             ce;
	logic             vout_above;
	logic             pgo;
	logic             settled;
	logic             rec;
	logic [11:0]      verr;
	logic [15:0]      bgain;
	logic [15:0]      gain;
	logic [15:0]      fev;
	logic [15:0]      cause;
	logic [LIN_W-1:0] ind;
	logic [1:0]       st;
	logic [15:0]      q;
	pgd_cmd_s         cmd;
	pgd_rsp_s         rsp;
	int               n_fail;
	int               cmp_count;
	int               cycles;

	// Short millisecond keeps the delay scenarios to a few cycles
	pgd_regs_top #(.CYC_PER_MS_P(4), .GAIN_W(16)) uut (
		.clk(clk), .resetn(resetn), .ce(ce), .cmd(cmd), .rsp(rsp),
		.vout_above_pg_on(vout_above), .power_good_output(pgo),
		.vout_error(verr), .base_gain(bgain), .adaptive_loop_gain(gain),
		.loop_settled(settled), .inductor_q16(ind), .fault_events(fev),
		.fault_capture_record(rec), .fault_capture_cause(cause)
	);
	pgd_host_model host (.clk(clk), .cmd(cmd), .rsp(rsp));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic check(input logic [47:0] seen, exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic t_reset();
		host.xfer(0, 8'hD4, 16'h0000, st, q);
		check(q, 16'hBA00, "delay reset");
		host.xfer(0, 8'hD5, 16'h0000, st, q);
		check(q, 16'h2064, "loop reset");
		host.xfer(0, 8'hD6, 16'h0000, st, q);
		check(q, 16'hAA66, "inductor reset");
		check(ind, 44'h4CC0, "inductor decode");
		host.xfer(0, 8'hD7, 16'h0000, st, q);
		check(q, 16'h0000, "mask reset");
		host.xfer(0, 8'hD8, 16'h1234, st, q);
		check({st, q}, 18'h20000, "unknown code");
		$display("test reset done");
	endtask

	task automatic t_delay_range();
		logic [15:0] w[6] = '{16'h0000, 16'h007D, 16'h007E, 16'h07FF,
			16'hF8FA, 16'hF8FB};
		logic [1:0] e[6] = '{2'b11, 2'b11, 2'b10, 2'b10, 2'b11, 2'b10};
		logic [15:0] held;
		held = 16'hBA00;
		for (int i = 0; i < 6; i++) begin
			host.xfer(1, 8'hD4, w[i], st, q);
			check(st, e[i], "delay write status");
			if (e[i] == 2'b11) held = w[i];
			host.xfer(0, 8'hD4, 16'h0000, st, q);
			check(q, held, "delay kept");
		end
		$display("test delay range done");
	endtask

	// Output must stay low after n-1 edges and be high after n
	task automatic pg_rise(input int n);
		vout_above = 1'b1;
		cyc(n - 1);
		check(pgo, 1'b0, "power good early");
		cyc(1);
		check(pgo, 1'b1, "power good late");
		vout_above = 1'b0;
		cyc(2);
		check(pgo, 1'b1, "power good fall early");
		cyc(1);
		check(pgo, 1'b0, "power good fall");
	endtask

	task automatic t_pg();
		host.xfer(1, 8'hD4, 16'h0002, st, q);
		cyc(4);
		pg_rise(12);
		vout_above = 1'b1;
		cyc(6);
		vout_above = 1'b0;
		cyc(1);
		check(pgo, 1'b0, "power good during glitch");
		pg_rise(12);
		host.xfer(1, 8'hD4, 16'h0000, st, q);
		pg_rise(4);
		$display("test power good done");
	endtask

	task automatic t_loop();
		bgain = 16'h8000;
		for (int d = 0; d < 4; d++) begin
			host.xfer(1, 8'hD5, {2'b00, 2'(d), 12'h100}, st, q);
			verr = 12'h100;
			cyc(2);
			check({settled, gain}, {1'b1, 16'h8000 >> d}, "gain cut");
			verr = 12'h101;
			cyc(2);
			check({settled, gain}, {1'b0, 16'h8000}, "gain full");
		end
		host.xfer(1, 8'hD5, 16'hFFFF, st, q);
		host.xfer(0, 8'hD5, 16'h0000, st, q);
		check(q, 16'h3FFF, "loop unused bits");
		verr = 12'hFFF;
		cyc(2);
		check({settled, gain}, {1'b1, 16'h1000}, "top threshold");
		$display("test loop done");
	endtask

	task automatic t_ind();
		logic [15:0] w[4] = '{16'h0064, 16'h0000, 16'h0065, 16'h07FF};
		logic [1:0] e[4] = '{2'b11, 2'b10, 2'b10, 2'b10};
		for (int i = 0; i < 4; i++) begin
			host.xfer(1, 8'hD6, w[i], st, q);
			check(st, e[i], "inductor write status");
			cyc(2);
			check(ind, 44'd100 << 16, "inductor value");
		end
		$display("test inductor done");
	endtask

	task automatic t_mask();
		for (int i = 0; i < 16; i++) begin
			host.xfer(1, 8'hD7, 16'h0000, st, q);
			fev = 16'h0001 << i;
			cyc(1);
			fev = 16'h0000;
			check(rec, i != 4, "capture unmasked");
			if (i != 4) check(cause, 16'h0001 << i, "capture cause");
			host.xfer(1, 8'hD7, 16'h0001 << i, st, q);
			host.xfer(0, 8'hD7, 16'h0000, st, q);
			check(q, 16'h0001 << i, "mask readback");
			fev = 16'h0001 << i;
			cyc(1);
			fev = 16'h0000;
			check(rec, 1'b0, "capture masked");
		end
		host.xfer(1, 8'hD7, 16'h0000, st, q);
		fev = 16'hFFFF;
		cyc(1);
		fev = 16'h0000;
		check({rec, cause}, {1'b1, 16'hFFEF}, "all faults");
		$display("test mask done");
	endtask

	// Reset in mid-run must bring back the reset values over written ones
	task automatic t_rst_mid();
		host.xfer(1, 8'hD5, 16'h1FFF, st, q);
		host.xfer(1, 8'hD7, 16'hFFFF, st, q);
		verr = 12'h000;
		cyc(2);
		check({settled, gain}, {1'b1, 16'h4000}, "gain before reset");
		resetn = 1'b0;
		cyc(1);
		check({settled, gain, pgo, rec}, 19'h0, "outputs in reset");
		cyc(2);
		resetn = 1'b1;
		cyc(1);
		check({settled, gain}, {1'b1, 16'h2000}, "reset divider");
		host.xfer(0, 8'hD5, 16'h0000, st, q);
		check(q, RST_LOOP, "loop after reset");
		host.xfer(0, 8'hD7, 16'h0000, st, q);
		check(q, RST_MASK, "mask after reset");
		host.xfer(0, 8'hD4, 16'h0000, st, q);
		check(q, RST_PG_DELAY, "delay after reset");
		$display("test mid reset done");
	endtask

	// Enable low freezes the synchroniser and counters, so nothing moves
	task automatic t_ce();
		ce = 1'b0;
		vout_above = 1'b1;
		fev = 16'h0001;
		cyc(10);
		check({pgo, rec}, 2'b00, "frozen by enable");
		ce = 1'b1;
		fev = 16'h0000;
		pg_rise(8);
		$display("test enable done");
	endtask

	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		vout_above = 1'b0;
		verr = 12'h000;
		bgain = 16'h0000;
		fev = 16'h0000;
		n_fail = 0;
		cmp_count = 0;
		cycles = 0;
		cyc(20);
		resetn = 1'b1;
		t_reset();
		t_delay_range();
		t_pg();
		t_loop();
		t_ind();
		t_mask();
		t_rst_mid();
		t_ce();
		stop_test();
	end
endmodule
`default_nettype wire
